// ===== hdl/lvd_consts.svh
// register offsets, field positions, reset values and timing counts of the supply monitor control block
`ifndef LVD_CONSTS_SVH
`define LVD_CONSTS_SVH

// printed offsets are not all word aligned: they are register indices, byte address is four times the index
`define LVD_MODE_IDX         32'hfffff890
`define LVD_LEVEL_IDX        32'hfffff891
`define LVD_MODE_ADDR        (`LVD_MODE_IDX << 2)
`define LVD_LEVEL_ADDR       (`LVD_LEVEL_IDX << 2)
`define LVD_PROTECT_ADDR     32'h00000000
`define LVD_STATUS_ADDR      32'h00000004

`define LVD_ENABLE_BIT       7
`define LVD_RESPONSE_BIT     1
`define LVD_FLAG_BIT         0
`define LVD_THRESHOLD_BIT    0
`define LVD_SETTLED_BIT      0

`define LVD_MODE_RST         8'h00
`define LVD_MODE_MONITOR_RST 8'h82
`define LVD_LEVEL_RST        8'h00

`define LVD_CLK_PERIOD_NS    50
`define LVD_SETTLE_NS        100000
`define LVD_SETTLE_CYC       ((`LVD_SETTLE_NS + `LVD_CLK_PERIOD_NS - 1) / `LVD_CLK_PERIOD_NS)

`define LVD_RESP_OKAY        2'h0
`define LVD_RESP_SLVERR      2'h2

`endif

// ===== hdl/lvd_pkg.sv
// types shared by the supply monitor control block
package lvd_pkg;

  typedef enum logic [2:0] {
    LVD_SEL_NONE    = 3'b000,
    LVD_SEL_MODE    = 3'b001,
    LVD_SEL_LEVEL   = 3'b010,
    LVD_SEL_PROTECT = 3'b011,
    LVD_SEL_STATUS  = 3'b100
  } lvd_sel_t;

  typedef enum logic [1:0] {
    LVD_BUS_IDLE = 2'b00,
    LVD_BUS_RESP = 2'b01
  } lvd_bus_st_t;

  typedef struct packed {
    logic detect_enable;
    logic response_select;
    logic threshold_choice;
  } lvd_ctrl_t;

endpackage

// ===== hdl/lvd_supply_monitor_ctrl.sv
// supply monitor control: mode and threshold registers behind an AXI4-Lite slave
//
// Contract
// [R1] mode register changes only via the protected write sequence; plain writes ignored
// [R2] mode register byte writable; bit 0 is read-only, writes to it ignored
// [R3] mode register 00h after pin, power-on-clear, watchdog reset; 82h after monitor reset
// [R4] threshold register clears on those resets, keeps its value across monitor reset
// [R5] mode bit 7 enables detection when set, disables when clear
// [R6] response bit 1 clear: low supply raises the undervoltage interrupt request
// [R7] response bit 1 set: low supply asserts the undervoltage system reset
// [R8] flag bit 0 reads 1 when supply low and enabled, else 0
// [R9] threshold bit 0: 0 picks the 4.4 V level, 1 picks 4.2 V
// [R10] software waits 0.1 ms after enabling before trusting the flag
// [R11] once reset response chosen, both registers locked until a non-monitor reset
// [R12] in interrupt mode the request follows the flag level directly
// [R13] unused register bits read zero and ignore writes
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/10ps
`include "lvd_consts.svh"

module lvd_supply_monitor_ctrl
  import lvd_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_monitor_reset,
  input  wire logic        i_supply_low,
  output logic             o_detect_enable,
  output logic             o_threshold_choice,
  output logic             o_undervoltage_irq,
  output logic             o_undervoltage_system_reset,
  input  wire logic [31:0] i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [31:0] i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready
);

  localparam int unsigned SETTLE_CYC = `LVD_SETTLE_CYC;
  localparam int unsigned CNT_W      = $clog2(SETTLE_CYC + 1);
  localparam logic [7:0]  MODE_MON_RST = `LVD_MODE_MONITOR_RST;

  function automatic lvd_sel_t decode(input logic [31:0] addr);
    if (addr == 32'(`LVD_MODE_ADDR)) begin
      return LVD_SEL_MODE;
    end else if (addr == 32'(`LVD_LEVEL_ADDR)) begin
      return LVD_SEL_LEVEL;
    end else if (addr == `LVD_PROTECT_ADDR) begin
      return LVD_SEL_PROTECT;
    end else if (addr == `LVD_STATUS_ADDR) begin
      return LVD_SEL_STATUS;
    end
    return LVD_SEL_NONE;
  endfunction

  // comparator output is asynchronous to i_clk
  logic              low_s1_r;
  logic              low_s2_r;

  lvd_ctrl_t         ctrl_r;
  lvd_ctrl_t         ctrl_nxt;
  logic              arm_r;
  logic              arm_nxt;
  logic              flag_r;
  logic              flag_nxt;
  logic              irq_nxt;
  logic              sysrst_nxt;
  logic [CNT_W-1:0]  settle_cnt_r;
  logic [CNT_W-1:0]  settle_cnt_nxt;

  lvd_bus_st_t       wst_r;
  lvd_bus_st_t       wst_nxt;
  logic              aw_have_r;
  logic              aw_have_nxt;
  logic              w_have_r;
  logic              w_have_nxt;
  logic [31:0]       waddr_r;
  logic [31:0]       waddr_nxt;
  logic [31:0]       wdata_r;
  logic [31:0]       wdata_nxt;
  logic              wlane0_r;
  logic              wlane0_nxt;
  logic [1:0]        bresp_nxt;
  lvd_bus_st_t       rst_r;
  lvd_bus_st_t       rst_nxt;
  logic [31:0]       rdata_nxt;
  logic [1:0]        rresp_nxt;
  lvd_sel_t          rsel_r;
  lvd_sel_t          rsel_nxt;

  logic              wr_go;
  lvd_sel_t          wsel;
  logic              settled;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      low_s1_r <= 1'b0;
      low_s2_r <= 1'b0;
    end else begin
      low_s1_r <= i_supply_low;
      low_s2_r <= low_s1_r;
    end
  end

  assign o_awready = (wst_r == LVD_BUS_IDLE) && !aw_have_r;
  assign o_wready  = (wst_r == LVD_BUS_IDLE) && !w_have_r;
  assign o_arready = (rst_r == LVD_BUS_IDLE);
  assign wr_go     = (wst_r == LVD_BUS_IDLE) && aw_have_r && w_have_r;
  assign wsel      = decode(waddr_r);
  assign settled   = (settle_cnt_r == CNT_W'(SETTLE_CYC));

  // ---------------- control state ----------------
  always_comb begin
    ctrl_nxt       = ctrl_r;
    arm_nxt        = arm_r;
    settle_cnt_nxt = settle_cnt_r;
    if (wr_go) begin
      // any write other than the command register disarms the sequence
      arm_nxt = (wsel == LVD_SEL_PROTECT) && wlane0_r;
      // response bit doubles as the lock; only a non-monitor reset clears it
      if (wlane0_r && !ctrl_r.response_select) begin // see [R11]
        if (wsel == LVD_SEL_MODE && arm_r) begin // see [R1]
          ctrl_nxt.detect_enable   = wdata_r[`LVD_ENABLE_BIT]; // see [R2]
          ctrl_nxt.response_select = wdata_r[`LVD_RESPONSE_BIT];
        end
        if (wsel == LVD_SEL_LEVEL) begin
          ctrl_nxt.threshold_choice = wdata_r[`LVD_THRESHOLD_BIT]; // see [R9]
        end
      end
    end
    if (i_monitor_reset) begin
      ctrl_nxt.detect_enable    = MODE_MON_RST[`LVD_ENABLE_BIT]; // see [R3]
      ctrl_nxt.response_select  = MODE_MON_RST[`LVD_RESPONSE_BIT];
      arm_nxt                   = 1'b0;
      // a bus write in the same cycle must not move the threshold
      ctrl_nxt.threshold_choice = ctrl_r.threshold_choice; // see [R4]
    end
    if (!ctrl_r.detect_enable) begin
      settle_cnt_nxt = '0;
    end else if (!settled) begin
      settle_cnt_nxt = settle_cnt_r + CNT_W'(1);
    end
    flag_nxt   = ctrl_r.detect_enable && low_s2_r; // see [R5] see [R8]
    irq_nxt    = flag_nxt && !ctrl_r.response_select; // see [R6] see [R12]
    sysrst_nxt = flag_nxt && ctrl_r.response_select; // see [R7]
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_r                      <= '0; // see [R3] see [R4]
      arm_r                       <= 1'b0;
      settle_cnt_r                <= '0;
      flag_r                      <= 1'b0;
      o_undervoltage_irq          <= 1'b0;
      o_undervoltage_system_reset <= 1'b0;
    end else begin
      ctrl_r                      <= ctrl_nxt;
      arm_r                       <= arm_nxt;
      settle_cnt_r                <= settle_cnt_nxt;
      flag_r                      <= flag_nxt;
      o_undervoltage_irq          <= irq_nxt;
      o_undervoltage_system_reset <= sysrst_nxt;
    end
  end

  assign o_detect_enable    = ctrl_r.detect_enable;
  assign o_threshold_choice = ctrl_r.threshold_choice;

  // ---------------- bus state ----------------
  always_comb begin
    wst_nxt     = wst_r;
    aw_have_nxt = aw_have_r;
    w_have_nxt  = w_have_r;
    waddr_nxt   = waddr_r;
    wdata_nxt   = wdata_r;
    wlane0_nxt  = wlane0_r;
    bresp_nxt   = o_bresp;
    rst_nxt     = rst_r;
    rdata_nxt   = o_rdata;
    rresp_nxt   = o_rresp;
    rsel_nxt    = rsel_r;
    if (o_awready && i_awvalid) begin
      aw_have_nxt = 1'b1;
      waddr_nxt   = i_awaddr;
    end
    if (o_wready && i_wvalid) begin
      w_have_nxt = 1'b1;
      wdata_nxt  = i_wdata;
      wlane0_nxt = i_wstrb[0];
    end
    case (wst_r)
      LVD_BUS_IDLE: begin
        if (wr_go) begin
          wst_nxt     = LVD_BUS_RESP;
          aw_have_nxt = 1'b0;
          w_have_nxt  = 1'b0;
          bresp_nxt   = (wsel == LVD_SEL_NONE) ? `LVD_RESP_SLVERR : `LVD_RESP_OKAY;
        end
      end
      LVD_BUS_RESP: begin
        if (i_bready) begin
          wst_nxt = LVD_BUS_IDLE;
        end
      end
      default: wst_nxt = LVD_BUS_IDLE;
    endcase
    case (rst_r)
      LVD_BUS_IDLE: begin
        if (i_arvalid) begin
          rst_nxt   = LVD_BUS_RESP;
          rsel_nxt  = decode(i_araddr);
          rdata_nxt = '0; // see [R13]
          rresp_nxt = `LVD_RESP_OKAY;
          case (rsel_nxt)
            LVD_SEL_MODE: begin
              rdata_nxt[`LVD_ENABLE_BIT]   = ctrl_r.detect_enable;
              rdata_nxt[`LVD_RESPONSE_BIT] = ctrl_r.response_select;
              rdata_nxt[`LVD_FLAG_BIT]     = flag_r; // see [R8]
            end
            LVD_SEL_LEVEL:   rdata_nxt[`LVD_THRESHOLD_BIT] = ctrl_r.threshold_choice;
            LVD_SEL_STATUS:  rdata_nxt[`LVD_SETTLED_BIT]   = settled; // see [R10]
            LVD_SEL_PROTECT: rdata_nxt = '0;
            default:         rresp_nxt = `LVD_RESP_SLVERR;
          endcase
        end
      end
      LVD_BUS_RESP: begin
        if (i_rready) begin
          rst_nxt = LVD_BUS_IDLE;
        end
      end
      default: rst_nxt = LVD_BUS_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wst_r     <= LVD_BUS_IDLE;
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      waddr_r   <= '0;
      wdata_r   <= '0;
      wlane0_r  <= 1'b0;
      o_bresp   <= `LVD_RESP_OKAY;
      rst_r     <= LVD_BUS_IDLE;
      o_rdata   <= '0;
      o_rresp   <= `LVD_RESP_OKAY;
      rsel_r    <= LVD_SEL_NONE;
    end else begin
      wst_r     <= wst_nxt;
      aw_have_r <= aw_have_nxt;
      w_have_r  <= w_have_nxt;
      waddr_r   <= waddr_nxt;
      wdata_r   <= wdata_nxt;
      wlane0_r  <= wlane0_nxt;
      o_bresp   <= bresp_nxt;
      rst_r     <= rst_nxt;
      o_rdata   <= rdata_nxt;
      o_rresp   <= rresp_nxt;
      rsel_r    <= rsel_nxt;
    end
  end

  assign o_bvalid = (wst_r == LVD_BUS_RESP);
  assign o_rvalid = (rst_r == LVD_BUS_RESP);

  // ---------------- checks ----------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  a_plain_write_ignored: assert property ( // see [R1]
    (wr_go && wsel == LVD_SEL_MODE && !arm_r && !i_monitor_reset)
      |=> (ctrl_r.detect_enable == $past(ctrl_r.detect_enable)
           && ctrl_r.response_select == $past(ctrl_r.response_select)))
    else $error("mode register changed by an unprotected write");

  a_monitor_reset_value: assert property ( // see [R3]
    i_monitor_reset |=> (ctrl_r.detect_enable && ctrl_r.response_select))
    else $error("mode register not 82h after monitor reset");

  a_level_kept_reset: assert property ( // see [R4]
    i_monitor_reset |=> $stable(ctrl_r.threshold_choice))
    else $error("threshold lost across monitor reset");

  a_flag_when_low: assert property ( // see [R8]
    (ctrl_r.detect_enable && low_s2_r) |=> flag_r)
    else $error("flag not raised while enabled and supply low");

  a_flag_off_disabled: assert property ( // see [R5]
    !ctrl_r.detect_enable |=> !flag_r && !o_undervoltage_irq && !o_undervoltage_system_reset)
    else $error("detector active while disabled");

  a_irq_follows_flag: assert property ( // see [R6]
    (ctrl_r.detect_enable && !ctrl_r.response_select)
      |=> (o_undervoltage_irq == flag_r) && !o_undervoltage_system_reset)
    else $error("interrupt does not follow flag in interrupt mode");

  a_reset_response: assert property ( // see [R7]
    (ctrl_r.detect_enable && ctrl_r.response_select && low_s2_r)
      |=> o_undervoltage_system_reset && !o_undervoltage_irq)
    else $error("system reset not asserted in reset mode");

  a_lock_holds: assert property ( // see [R11]
    (ctrl_r.response_select && !i_monitor_reset)
      |=> ctrl_r.response_select && ctrl_r.detect_enable == $past(ctrl_r.detect_enable)
          && $stable(ctrl_r.threshold_choice))
    else $error("locked registers changed");

  a_unused_read_zero: assert property ( // see [R13]
    (o_rvalid && rsel_r == LVD_SEL_MODE) |-> (o_rdata[6:2] == 5'h00 && o_rdata[31:8] == 24'h000000))
    else $error("unused mode bits read nonzero");

  a_bresp_hold: assert property (
    (o_bvalid && !i_bready) |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped before taken");

  c_irq_raised:      cover property (o_undervoltage_irq);
  c_sysrst_raised:   cover property (o_undervoltage_system_reset);
  c_protected_write: cover property (wr_go && wsel == LVD_SEL_MODE && arm_r);
  c_settled:         cover property (ctrl_r.detect_enable && settled);

endmodule

// ===== verif/lvd_supply_comparator_model.sv
// behavioural model of the analog supply comparator facing the monitor control block
`timescale 1ns/10ps

module lvd_supply_comparator_model (
  input  wire logic        i_clk,
  input  wire logic        i_powered,
  input  wire logic        i_threshold_choice,
  input  wire logic [15:0] i_supply_mv,
  output logic             o_supply_low
);
  logic low_r = 1'b0;

  // unpowered comparator output is garbage: toggle so any missing gate shows up
  always @(posedge i_clk) begin
    if (i_powered) begin
      // thresholds in millivolts: 4.2 V and 4.4 V
      low_r <= i_supply_mv < (i_threshold_choice ? 16'h1068 : 16'h1130);
    end else begin
      low_r <= ~low_r;
    end
  end

  assign o_supply_low = low_r;
endmodule

// ===== verif/lvd_supply_monitor_ctrl_tb_top.sv
// register-level testbench of the supply monitor control block
`timescale 1ns/10ps
`include "lvd_consts.svh"

module lvd_supply_monitor_ctrl_tb_top;
  localparam logic [31:0] mode_a = `LVD_MODE_ADDR;
  localparam logic [31:0] lvl_a  = `LVD_LEVEL_ADDR;
  localparam logic [1:0]  ok     = `LVD_RESP_OKAY;
  localparam logic [1:0]  er     = `LVD_RESP_SLVERR;
  // comparator input in millivolts: 5.0 V, 4.3 V and 4.1 V
  localparam logic [15:0] mv_ok  = 16'h1388;
  localparam logic [15:0] mv_mid = 16'h10cc;
  localparam logic [15:0] mv_low = 16'h1004;

  logic        i_clk;
  logic        i_arst_n;
  logic        i_monitor_reset;
  logic        i_supply_low;
  logic        o_detect_enable;
  logic        o_threshold_choice;
  logic        o_undervoltage_irq;
  logic        o_undervoltage_system_reset;
  logic [31:0] i_awaddr;
  logic [31:0] i_wdata;
  logic [31:0] i_araddr;
  logic [31:0] o_rdata;
  logic [3:0]  i_wstrb;
  logic        i_awvalid;
  logic        o_awready;
  logic        i_wvalid;
  logic        o_wready;
  logic        o_bvalid;
  logic        i_bready;
  logic        i_arvalid;
  logic        o_arready;
  logic        o_rvalid;
  logic        i_rready;
  logic [1:0]  o_bresp;
  logic [1:0]  o_rresp;
  logic [15:0] supply_mv;
  int          fails;
  int          checked;
  int          cycles;

  lvd_supply_monitor_ctrl u_lvd_supply_monitor_ctrl (
    .i_clk, .i_arst_n, .i_monitor_reset, .i_supply_low, .o_detect_enable, .o_threshold_choice,
    .o_undervoltage_irq, .o_undervoltage_system_reset, .i_awaddr, .i_awvalid, .o_awready, .i_wdata,
    .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready,
    .o_rdata, .o_rresp, .o_rvalid, .i_rready
  );

  lvd_supply_comparator_model u_lvd_supply_comparator_model (
    .i_clk              (i_clk),
    .i_powered          (o_detect_enable),
    .i_threshold_choice (o_threshold_choice),
    .i_supply_mv        (supply_mv),
    .o_supply_low       (i_supply_low)
  );

  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  task automatic results();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // a hung handshake ends here instead of spinning forever
  always @(posedge i_clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      results();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    chk({30'h0, got}, {30'h0, exp});
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
    logic aw;
    logic w;
    @(posedge i_clk);
    i_awaddr <= a;
    i_wdata <= d;
    i_wstrb <= s;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    while (aw || w) begin
      @(posedge i_clk);
      if (aw && o_awready) begin
        aw = 1'b0;
        i_awvalid <= 1'b0;
      end
      if (w && o_wready) begin
        w = 1'b0;
        i_wvalid <= 1'b0;
      end
    end
    while (o_bvalid !== 1'b1) @(posedge i_clk);
    i_bready <= 1'b0;
    chk_resp(o_bresp, r);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] r);
    @(posedge i_clk);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    do @(posedge i_clk); while (o_arready !== 1'b1);
    i_arvalid <= 1'b0;
    do @(posedge i_clk); while (o_rvalid !== 1'b1);
    i_rready <= 1'b0;
    chk(o_rdata, exp);
    chk_resp(o_rresp, r);
  endtask

  // protected write: arm, then the very next write hits the mode register
  task automatic pwr(input logic [31:0] d);
    wr(`LVD_PROTECT_ADDR, 32'h0, 4'h1, ok);
    wr(mode_a, d, 4'h1, ok);
  endtask

  task automatic supply(input logic [15:0] mv);
    supply_mv <= mv;
    repeat (5) @(posedge i_clk);
  endtask

  initial begin
    {i_arst_n, i_monitor_reset, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = '0;
    {i_awaddr, i_wdata, i_araddr, i_wstrb} = '0;
    supply_mv = mv_ok;
    fails = 0;
    checked = 0;
    cycles = 0;
    repeat (6) @(posedge i_clk);
    i_arst_n <= 1'b1;
    rd(mode_a, 32'h0, ok);
    rd(lvl_a, 32'h0, ok);
    rd(`LVD_PROTECT_ADDR, 32'h0, ok);
    wr(mode_a, 32'h80, 4'h1, ok);
    rd(mode_a, 32'h0, ok);
    wr(`LVD_PROTECT_ADDR, 32'h0, 4'h1, ok);
    wr(lvl_a, 32'hff, 4'hf, ok);
    wr(mode_a, 32'h80, 4'h1, ok);
    rd(mode_a, 32'h0, ok);
    // lane 0 strobe low: the byte-wide register must not take it
    wr(lvl_a, 32'h0, 4'he, ok);
    rd(lvl_a, 32'h1, ok);
    chk_pin(o_threshold_choice, 1'b1);
    pwr(32'h7d);
    rd(mode_a, 32'h0, ok);
    pwr(32'hffffff81);
    chk_pin(o_detect_enable, 1'b1);
    rd(`LVD_STATUS_ADDR, 32'h0, ok);
    // the comparator has only just been powered: its flag is not trusted yet
    repeat (`LVD_SETTLE_CYC) @(posedge i_clk);
    rd(`LVD_STATUS_ADDR, 32'h1, ok);
    rd(mode_a, 32'h80, ok);
    supply(mv_mid);
    chk_pin(o_undervoltage_irq, 1'b0);
    wr(lvl_a, 32'h0, 4'h1, ok);
    repeat (5) @(posedge i_clk);
    chk_pin(o_undervoltage_irq, 1'b1);
    chk_pin(o_undervoltage_system_reset, 1'b0);
    rd(mode_a, 32'h81, ok);
    supply(mv_ok);
    chk_pin(o_undervoltage_irq, 1'b0);
    supply(mv_mid);
    pwr(32'h0);
    repeat (5) @(posedge i_clk);
    rd(mode_a, 32'h0, ok);
    chk_pin(o_undervoltage_irq, 1'b0);
    rd(32'h8, 32'h0, er);
    wr(32'h8, 32'h1, 4'hf, er);
    supply(mv_ok);
    wr(lvl_a, 32'h1, 4'h1, ok);
    @(posedge i_clk);
    i_monitor_reset <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_monitor_reset <= 1'b0;
    supply(mv_ok);
    rd(mode_a, 32'h82, ok);
    rd(lvl_a, 32'h1, ok);
    pwr(32'h80);
    rd(mode_a, 32'h82, ok);
    wr(lvl_a, 32'h0, 4'h1, ok);
    rd(lvl_a, 32'h1, ok);
    supply(mv_low);
    chk_pin(o_undervoltage_system_reset, 1'b1);
    chk_pin(o_undervoltage_irq, 1'b0);
    rd(mode_a, 32'h83, ok);
    supply(mv_ok);
    chk_pin(o_undervoltage_system_reset, 1'b0);
    i_arst_n <= 1'b0;
    repeat (6) @(posedge i_clk);
    i_arst_n <= 1'b1;
    rd(mode_a, 32'h0, ok);
    rd(lvl_a, 32'h0, ok);
    pwr(32'h80);
    supply(mv_ok);
    rd(mode_a, 32'h80, ok);
    // software picks the reset response itself: both registers lock
    pwr(32'h82);
    wr(lvl_a, 32'h1, 4'h1, ok);
    rd(lvl_a, 32'h0, ok);
    pwr(32'h0);
    rd(mode_a, 32'h82, ok);
    results();
  end
endmodule
